// ==== logic/gpio_irq_filter_output_ctrl.sv ====
// gpio port: interrupt detect with glitch filter, pin level readback, output level strobes
// assumes pins synchronous to i_clk and slow clock sources already one-cycle enable pulses
//
// Notes on behaviour
// [R01] low level raises flag when enabled
// [R02] pending flags read-only, one per pin
// [R03] writing zero clears flag, one ignored
// [R04] clear register reads implemented-pin ones
// [R05] three-bit field picks filter sampling clock
// [R06] select 111 passes inputs unfiltered
// [R07] per-pin enable routes pin through filter
// [R08] pulses shorter than filter period dropped
// [R09] input register returns present pin levels
// [R10] input register reset value per port
// [R11] output register drives pin levels
// [R12] clear strobe clears output bits, reads zero
// [R13] set field sets output bits, reads zero
// [R14] upper field clears output bits
// [R15] set wins over clear in one write
// [R16] invert strobe toggles output bits
// [R17] rising edge raises flag when enabled
// [R18] falling edge raises flag when enabled
// [R19] high level raises flag when enabled
// [R20] new event beats same-cycle clear
// [R21] persisting level re-raises cleared flag
// [R22] port request while any flag pending
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module gpio_irq_filter_output_ctrl
    import gpio_irq_pkg::*;
#(
    parameter int unsigned PORT_INDEX = 0  // 0, 1 or 2 picks implemented pins and reset levels
)
(
    // clock and reset
    input  wire logic                     i_clk,
    input  wire logic                     i_arst_n,
    // pins
    input  wire logic [PIN_COUNT-1:0]     i_pin,
    output logic      [PIN_COUNT-1:0]     o_pin,
    // slow filter sources, one-cycle enables
    input  wire logic                     i_tmr_ovf,
    input  wire logic                     i_tick_150k,
    input  wire logic                     i_tick_lso,
    input  wire logic                     i_tick_10k,
    // port interrupt request
    output logic                          o_irq,
    // AXI4-Lite write address
    input  wire logic                     i_awvalid,
    output logic                          o_awready,
    input  wire gpio_irq_pkg::axi_addr_type  i_aw,
    // AXI4-Lite write data
    input  wire logic                     i_wvalid,
    output logic                          o_wready,
    input  wire gpio_irq_pkg::axi_wdata_type i_w,
    // AXI4-Lite write response
    output logic                          o_bvalid,
    input  wire logic                     i_bready,
    output logic      [1:0]               o_bresp,
    // AXI4-Lite read address
    input  wire logic                     i_arvalid,
    output logic                          o_arready,
    input  wire gpio_irq_pkg::axi_addr_type  i_ar,
    // AXI4-Lite read data
    output logic                          o_rvalid,
    input  wire logic                     i_rready,
    output logic      [31:0]              o_rdata,
    output logic      [1:0]               o_rresp
);
    import gpio_irq_pkg::*;

    // implemented pins and reset input level of this port
    localparam logic [7:0] IMPL_MASK = (PORT_INDEX == 2) ? PORT_C_IMPL : PORT_A_IMPL;
    localparam logic [7:0] LVL_RST   = (PORT_INDEX == 0) ? PORT_A_LVL
                                     : (PORT_INDEX == 1) ? PORT_B_LVL : PORT_C_LVL;

    // address hit check, used for both read and write decode
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == RISE_IE_OFS) || (a == FALL_IE_OFS) || (a == HIGH_IE_OFS)
                 || (a == LOW_IE_OFS)  || (a == PEND_OFS)    || (a == FCLR_OFS)
                 || (a == FILT_OFS)    || (a == PIN_LVL_OFS) || (a == OUT_LVL_OFS)
                 || (a == CLR_STB_OFS) || (a == SETCLR_OFS)  || (a == INV_STB_OFS);
    endfunction : is_mapped

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0]   rise_ie_r, fall_ie_r, high_ie_r, low_level_irq_en_r;
    logic [7:0]   filt_en_r;
    logic [2:0]   filter_clock_select_r;
    logic [7:0]   pending_flags_r, pending_flags_nxt;
    logic [7:0]   pin_level_r;
    logic [7:0]   output_level_r, output_level_nxt;
    logic [7:0]   filt_lvl_r, filt_prev_r, filt_cand_r;
    logic [2:0]   div_cnt_r;

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    logic                aw_held_r, w_held_r;
    logic [ADDR_W-1:0]   aw_addr_r;
    logic [31:0]         w_data_r;
    logic [3:0]          w_strb_r;
    logic                bvalid_r;
    logic [1:0]          bresp_r;
    wire                 aw_take  = i_awvalid && o_awready;
    wire                 w_take   = i_wvalid && o_wready;
    wire                 wr_go    = aw_held_r && w_held_r && !bvalid_r;
    wire logic [7:0]     wr_lane  = w_strb_r[0] ? w_data_r[7:0] : 8'h00;
    wire logic [7:0]     wr_keep  = w_strb_r[0] ? w_data_r[7:0] : 8'hFF;
    wire logic [6:0]     wr_clr_fld = w_strb_r[2] ? w_data_r[CLR_FLD_MSB:CLR_FLD_LSB] : 7'h00;
    wire                 wr_hit   = is_mapped(aw_addr_r);

    assign o_awready = !aw_held_r;
    assign o_wready  = !w_held_r;
    assign o_bvalid  = bvalid_r;
    assign o_bresp   = bresp_r;

    // hold address and data until both are present, then answer
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            aw_addr_r <= '0;
            w_data_r  <= '0;
            w_strb_r  <= '0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
        end
        else
        begin
            if (aw_take)
            begin
                aw_held_r <= 1'b1;
                aw_addr_r <= i_aw.addr;
            end
            if (w_take)
            begin
                w_held_r <= 1'b1;
                w_data_r <= i_w.data;
                w_strb_r <= i_w.strb;
            end
            if (wr_go)
            begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid_r && i_bready)
            begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // write strobes per register
    wire we_rise   = wr_go && (aw_addr_r == RISE_IE_OFS);
    wire we_fall   = wr_go && (aw_addr_r == FALL_IE_OFS);
    wire we_high   = wr_go && (aw_addr_r == HIGH_IE_OFS);
    wire we_low    = wr_go && (aw_addr_r == LOW_IE_OFS);
    wire we_fclr   = wr_go && (aw_addr_r == FCLR_OFS);
    wire we_filt   = wr_go && (aw_addr_r == FILT_OFS);
    wire we_out    = wr_go && (aw_addr_r == OUT_LVL_OFS);
    wire we_clrstb = wr_go && (aw_addr_r == CLR_STB_OFS);
    wire we_setclr = wr_go && (aw_addr_r == SETCLR_OFS);
    wire we_inv    = wr_go && (aw_addr_r == INV_STB_OFS);

    // configuration registers
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rise_ie_r             <= '0;
            fall_ie_r             <= '0;
            high_ie_r             <= '0;
            low_level_irq_en_r    <= '0;
            filt_en_r             <= '0;
            filter_clock_select_r <= FCLK_RST;
        end
        else
        begin
            if (we_rise && w_strb_r[0]) rise_ie_r <= w_data_r[7:0];
            if (we_fall && w_strb_r[0]) fall_ie_r <= w_data_r[7:0];
            if (we_high && w_strb_r[0]) high_ie_r <= w_data_r[7:0];
            if (we_low && w_strb_r[0])  low_level_irq_en_r <= w_data_r[7:0];
            if (we_filt && w_strb_r[0]) filt_en_r <= w_data_r[7:0];
            if (we_filt && w_strb_r[2])
                filter_clock_select_r <= w_data_r[FCLK_SEL_MSB:FCLK_SEL_LSB];
        end
    end

    // ------------------------------------------------------------
    // filter sampling enable
    // ------------------------------------------------------------
    logic filt_tick;
    always_comb
    begin
        case (fclk_sel_type'(filter_clock_select_r))                      // R05
            FCLK_DIV2:  filt_tick = div_cnt_r[0];
            FCLK_DIV4:  filt_tick = &div_cnt_r[1:0];
            FCLK_DIV8:  filt_tick = &div_cnt_r;
            FCLK_TMR:   filt_tick = i_tmr_ovf;
            FCLK_O150K: filt_tick = i_tick_150k;
            FCLK_LSO:   filt_tick = i_tick_lso;
            FCLK_O10K:  filt_tick = i_tick_10k;
            default:    filt_tick = 1'b0;                                 // R06
        endcase
    end
    wire filt_off = (filter_clock_select_r == FCLK_NONE);                 // R06

    // bus clock divider for the /2, /4, /8 selections
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n) div_cnt_r <= '0;
        else           div_cnt_r <= div_cnt_r + DIV_ONE;
    end

    // ------------------------------------------------------------
    // per-pin filter: level must hold across two sampling ticks
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < PIN_COUNT; g++)
        begin : g_filt
            always_ff @(posedge i_clk or negedge i_arst_n)
            begin
                if (!i_arst_n)
                begin
                    filt_cand_r[g] <= 1'b0;
                    filt_lvl_r[g]  <= 1'b0;
                end
                else if (!filt_en_r[g] || filt_off)                       // R07
                begin
                    filt_cand_r[g] <= i_pin[g];
                    filt_lvl_r[g]  <= i_pin[g];
                end
                else if (filt_tick)
                begin
                    filt_cand_r[g] <= i_pin[g];
                    if (filt_cand_r[g] == i_pin[g])                       // R08
                        filt_lvl_r[g] <= i_pin[g];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // event detection and pending flags
    // ------------------------------------------------------------
    wire logic [7:0] irq_in = filt_lvl_r;
    wire logic [7:0] ev_rise = irq_in & ~filt_prev_r & rise_ie_r;         // R17
    wire logic [7:0] ev_fall = ~irq_in & filt_prev_r & fall_ie_r;         // R18
    wire logic [7:0] ev_high = irq_in & high_ie_r;                        // R19 R21
    wire logic [7:0] ev_low  = ~irq_in & low_level_irq_en_r;              // R01 R21
    wire logic [7:0] ev_any  = (ev_rise | ev_fall | ev_high | ev_low) & IMPL_MASK;
    wire logic [7:0] fl_clr  = we_fclr ? ~wr_keep : 8'h00;                // R03

    assign pending_flags_nxt = (pending_flags_r & ~fl_clr) | ev_any;      // R20

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            pending_flags_r <= '0;
            filt_prev_r     <= '0;
            pin_level_r     <= LVL_RST;                                   // R10
        end
        else
        begin
            pending_flags_r <= pending_flags_nxt;
            filt_prev_r     <= irq_in;
            pin_level_r     <= i_pin;                                     // R09
        end
    end

    assign o_irq = |pending_flags_r;                                      // R22

    // ------------------------------------------------------------
    // output level register and its strobes
    // ------------------------------------------------------------
    wire logic [7:0] set_bits = we_setclr ? wr_lane : 8'h00;              // R13
    wire logic [7:0] clr_bits = (we_setclr ? {1'b0, wr_clr_fld} : 8'h00)  // R14
                              | (we_clrstb ? wr_lane : 8'h00);            // R12
    wire logic [7:0] inv_bits = we_inv ? wr_lane : 8'h00;                 // R16

    assign output_level_nxt = we_out && w_strb_r[0] ? w_data_r[7:0]      // R11
                            : ((output_level_r & ~clr_bits) | set_bits) ^ inv_bits; // R15

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n) output_level_r <= OUT_LVL_RST;
        else           output_level_r <= output_level_nxt;
    end

    assign o_pin = output_level_r;                                        // R11

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
    logic [31:0] rd_mux;
    wire         ar_take = i_arvalid && o_arready;

    assign o_arready = !rvalid_r;
    assign o_rvalid  = rvalid_r;
    assign o_rdata   = rdata_r;
    assign o_rresp   = rresp_r;

    // read data select; strobe registers read as zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (i_ar.addr == RISE_IE_OFS)      rd_mux[7:0] = rise_ie_r;
        else if (i_ar.addr == FALL_IE_OFS) rd_mux[7:0] = fall_ie_r;
        else if (i_ar.addr == HIGH_IE_OFS) rd_mux[7:0] = high_ie_r;
        else if (i_ar.addr == LOW_IE_OFS)  rd_mux[7:0] = low_level_irq_en_r;
        else if (i_ar.addr == PEND_OFS)    rd_mux[7:0] = pending_flags_r;   // R02
        else if (i_ar.addr == FCLR_OFS)    rd_mux[7:0] = IMPL_MASK;         // R04
        else if (i_ar.addr == FILT_OFS)
        begin
            rd_mux[7:0] = filt_en_r;
            rd_mux[FCLK_SEL_MSB:FCLK_SEL_LSB] = filter_clock_select_r;
        end
        else if (i_ar.addr == PIN_LVL_OFS) rd_mux[7:0] = pin_level_r;       // R09
        else if (i_ar.addr == OUT_LVL_OFS) rd_mux[7:0] = output_level_r;
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rvalid_r <= 1'b0;
            rdata_r  <= '0;
            rresp_r  <= RESP_OKAY;
        end
        else if (ar_take)
        begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_mux;
            rresp_r  <= is_mapped(i_ar.addr) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid_r && i_rready)
        begin
            rvalid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    low_level_flag_a: assert property (                                   // R01
        (~filt_lvl_r[0] && low_level_irq_en_r[0]) |=> pending_flags_r[0])
        else $error("low level did not raise flag");
    flag_hold_a: assert property (                                        // R02
        (pending_flags_r == 8'h00 && ev_any == 8'h00) |=> pending_flags_r == 8'h00)
        else $error("flag rose with no event");
    flag_clear_a: assert property (                                       // R03
        (we_fclr && w_strb_r[0] && !w_data_r[0] && ev_any[0] == 1'b0) |=> !pending_flags_r[0])
        else $error("write zero did not clear flag");
    set_wins_a: assert property (                                         // R20
        ev_any[0] |=> pending_flags_r[0])
        else $error("event lost against clear");
    irq_follows_a: assert property (                                      // R22
        o_irq == (pending_flags_r != 8'h00))
        else $error("irq disagrees with flags");
    set_priority_a: assert property (                                     // R15
        (we_setclr && w_strb_r[0] && w_strb_r[2] && w_data_r[0] && w_data_r[16]
         && !we_inv) |=> o_pin[0])
        else $error("set did not win over clear");
    toggle_out_a: assert property (                                       // R16
        (we_inv && w_strb_r[0] && w_data_r[1]) |=> o_pin[1] != $past(o_pin[1]))
        else $error("toggle did not invert");
    clr_strobe_a: assert property (                                       // R12
        (we_clrstb && w_strb_r[0] && w_data_r[2]) |=> !o_pin[2])
        else $error("clear strobe missed");
    bypass_filter_a: assert property (                                    // R07
        (!filt_en_r[3]) |=> filt_lvl_r[3] == $past(i_pin[3]))
        else $error("unfiltered pin did not pass");
    read_answer_a: assert property (
        ar_take |=> o_rvalid)
        else $error("read not answered");

    wr_cover_c:   cover property (wr_go ##1 o_bvalid && i_bready);
    flag_cover_c: cover property (ev_any[0] ##[1:4] we_fclr);
    filt_cover_c: cover property (filt_en_r[0] && filt_tick && filt_cand_r[0] != i_pin[0]);
endmodule : gpio_irq_filter_output_ctrl

// ==== include/gpio_irq_pkg.sv ====
// register map, field layout and timing constants for the gpio interrupt/output port
// assumes an AXI4-Lite master with 32-bit data and a 25 MHz bus clock
package gpio_irq_pkg;
    localparam int unsigned PIN_COUNT = 8;
    localparam int unsigned ADDR_W    = 8;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] RISE_IE_OFS  = 8'h24;
    localparam logic [ADDR_W-1:0] FALL_IE_OFS  = 8'h28;
    localparam logic [ADDR_W-1:0] HIGH_IE_OFS  = 8'h2C;
    localparam logic [ADDR_W-1:0] LOW_IE_OFS   = 8'h30;
    localparam logic [ADDR_W-1:0] PEND_OFS     = 8'h34;
    localparam logic [ADDR_W-1:0] FCLR_OFS     = 8'h38;
    localparam logic [ADDR_W-1:0] FILT_OFS     = 8'h40;
    localparam logic [ADDR_W-1:0] PIN_LVL_OFS  = 8'h50;
    localparam logic [ADDR_W-1:0] OUT_LVL_OFS  = 8'h54;
    localparam logic [ADDR_W-1:0] CLR_STB_OFS  = 8'h58;
    localparam logic [ADDR_W-1:0] SETCLR_OFS   = 8'h5C;
    localparam logic [ADDR_W-1:0] INV_STB_OFS  = 8'h60;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned FCLK_SEL_LSB = 16;
    localparam int unsigned FCLK_SEL_MSB = 18;
    localparam int unsigned CLR_FLD_LSB  = 16;
    localparam int unsigned CLR_FLD_MSB  = 22;

    // ------------------------------------------------------------
    // implemented-pin masks and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] PORT_A_IMPL  = 8'hFF;
    localparam logic [7:0] PORT_C_IMPL  = 8'h3F;
    localparam logic [7:0] PORT_A_LVL   = 8'h24;
    localparam logic [7:0] PORT_B_LVL   = 8'h00;
    localparam logic [7:0] PORT_C_LVL   = 8'h20;
    localparam logic [7:0] OUT_LVL_RST  = 8'h00;
    localparam logic [2:0] FCLK_RST     = 3'h0;

    // ------------------------------------------------------------
    // filter clock selections
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        FCLK_DIV2  = 3'b000,
        FCLK_DIV4  = 3'b001,
        FCLK_DIV8  = 3'b010,
        FCLK_TMR   = 3'b011,
        FCLK_O150K = 3'b100,
        FCLK_LSO   = 3'b101,
        FCLK_O10K  = 3'b110,
        FCLK_NONE  = 3'b111
    } fclk_sel_type;

    // bus clock divider count step (divide by 2, 4, 8)
    localparam logic [2:0] DIV_ONE = 3'h1;

    // AXI4-Lite responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // write channel payloads travel as structs
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
    } axi_addr_type;

    typedef struct packed {
        logic [31:0] data;
        logic [3:0]  strb;
    } axi_wdata_type;
endpackage : gpio_irq_pkg

// ==== verif/pin_board.sv ====
// board model: drives the port pins at the level the bench requests
// assumes requests change at rising edges of the port clock
`timescale 1ns/1ps
module pin_board
(
    // clock
    input  wire logic       i_clk,
    // requested and driven levels
    input  wire logic [7:0] i_req,
    output logic      [7:0] o_lvl
);
    // pins settle one clock after the request, low from time zero
    initial o_lvl = 8'h00;
    always @(posedge i_clk)
    begin
        o_lvl <= i_req;
    end
endmodule : pin_board

// ==== verif/tb_top.sv ====
// bench for the gpio interrupt/output port, port index 0
// assumes a 25 MHz clock and the pin board model on the pins
`timescale 1ns/1ps
module tb_top;
    import gpio_irq_pkg::*;
    logic i_clk = 1'b0, i_arst_n = 1'b0, awv = 1'b0, wv = 1'b0, brdy = 1'b0;
    logic arv = 1'b0, rrdy = 1'b0, tick = 1'b0, awr, wr, bv, arr, rv, irq;
    logic [7:0] req = 8'h00, pin, opin, tcnt = 8'h00;
    logic [1:0] bresp, rresp, wresp;
    logic [31:0] rdata, d;
    axi_addr_type aw = '0, ar = '0;
    axi_wdata_type w = '0;
    int n_errors = 0, tests_run = 0, cyc = 0;
    gpio_irq_filter_output_ctrl #(.PORT_INDEX(0)) i_gpio_irq_filter_output_ctrl (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_pin(pin), .o_pin(opin),
        .i_tmr_ovf(tick), .i_tick_150k(tick), .i_tick_lso(tick), .i_tick_10k(tick),
        .o_irq(irq), .i_awvalid(awv), .o_awready(awr), .i_aw(aw), .i_wvalid(wv),
        .o_wready(wr), .i_w(w), .o_bvalid(bv), .i_bready(brdy), .o_bresp(bresp),
        .i_arvalid(arv), .o_arready(arr), .i_ar(ar), .o_rvalid(rv), .i_rready(rrdy),
        .o_rdata(rdata), .o_rresp(rresp));
    pin_board i_pin_board (.i_clk(i_clk), .i_req(req), .o_lvl(pin));
    // ---------------------------------------------
    // clock, slow ticks, watchdog
    // ---------------------------------------------
    initial forever #20 i_clk = ~i_clk;
    always @(posedge i_clk)
    begin
        tcnt <= tcnt + 8'h01;
        tick <= (tcnt[3:0] == 4'h0);
        cyc  <= cyc + 1;
        if (cyc == 20000) begin n_errors++; end_sim(); end
    end
    task automatic end_sim();
        if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask : chk
    // ---------------------------------------------
    // bus tasks
    // ---------------------------------------------
    task automatic wr32(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s = 4'hF);
        @(posedge i_clk);
        aw.addr <= a; w.data <= v; w.strb <= s; awv <= 1'b1; wv <= 1'b1; brdy <= 1'b1;
        forever
        begin
            @(posedge i_clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr) wv <= 1'b0;
            if (bv) begin wresp = bresp; brdy <= 1'b0; break; end
        end
    endtask : wr32
    task automatic rd32(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        @(posedge i_clk);
        ar.addr <= a; arv <= 1'b1; rrdy <= 1'b1;
        forever
        begin
            @(posedge i_clk);
            if (arv && arr) arv <= 1'b0;
            if (rv) begin v = rdata; r = rresp; rrdy <= 1'b0; break; end
        end
    endtask : rd32
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [1:0] r;
        rd32(a, d, r);
        chk(d, exp);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
    endtask : rchk
    task automatic pins(input logic [7:0] v);
        @(posedge i_clk);
        req <= v;
        repeat (10) @(posedge i_clk);
    endtask : pins
    task automatic pulse0(input int n);
        @(posedge i_clk);
        req <= req | 8'h01;
        repeat (n) @(posedge i_clk);
        req <= req & 8'hFE;
        repeat (12) @(posedge i_clk);
    endtask : pulse0
    // ---------------------------------------------
    // scenarios
    // ---------------------------------------------
    task automatic t_reset();
        rchk(FCLR_OFS, 32'h0000_00FF);
        rchk(PEND_OFS, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
    endtask : t_reset
    task automatic t_out();
        wr32(OUT_LVL_OFS, 32'h0000_00A5);
        chk({30'h0, wresp}, {30'h0, RESP_OKAY});
        rchk(OUT_LVL_OFS, 32'h0000_00A5);
        chk({24'h0, opin}, 32'h0000_00A5);
        wr32(CLR_STB_OFS, 32'h0000_0005);
        rchk(OUT_LVL_OFS, 32'h0000_00A0);
        rchk(CLR_STB_OFS, 32'h0000_0000);
        wr32(SETCLR_OFS, 32'h0021_000F);
        chk({24'h0, opin}, 32'h0000_008F);
        rchk(SETCLR_OFS, 32'h0000_0000);
        wr32(INV_STB_OFS, 32'h0000_00FF);
        rchk(OUT_LVL_OFS, 32'h0000_0070);
        rchk(INV_STB_OFS, 32'h0000_0000);
    endtask : t_out
    task automatic t_irq();
        wr32(RISE_IE_OFS, 32'h0000_0001);
        pins(8'h01);
        rchk(PEND_OFS, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0001);
        wr32(PEND_OFS, 32'h0000_0000);
        wr32(FCLR_OFS, 32'h0000_00FF);
        rchk(PEND_OFS, 32'h0000_0001);
        wr32(FCLR_OFS, 32'h0000_00FE);
        rchk(PEND_OFS, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
        wr32(RISE_IE_OFS, 32'h0000_0000);
        pins(8'h03);
        wr32(FALL_IE_OFS, 32'h0000_0002);
        pins(8'h01);
        rchk(PEND_OFS, 32'h0000_0002);
        wr32(FALL_IE_OFS, 32'h0000_0000);
        wr32(HIGH_IE_OFS, 32'h0000_0004);
        pins(8'h05);
        wr32(FCLR_OFS, 32'h0000_00F9);
        rchk(PEND_OFS, 32'h0000_0004);
        wr32(HIGH_IE_OFS, 32'h0000_0000);
        wr32(LOW_IE_OFS, 32'h0000_0008);
        wr32(FCLR_OFS, 32'h0000_00FB);
        rchk(PEND_OFS, 32'h0000_0008);
        wr32(LOW_IE_OFS, 32'h0000_0000);
        wr32(FCLR_OFS, 32'h0000_0000);
        rchk(PEND_OFS, 32'h0000_0000);
        pins(8'hC3);
        rchk(PIN_LVL_OFS, 32'h0000_00C3);
    endtask : t_irq
    task automatic t_filter();
        logic [1:0] r;
        pins(8'h00);
        wr32(FILT_OFS, 32'h0000_0001);
        wr32(RISE_IE_OFS, 32'h0000_0001);
        wr32(FCLR_OFS, 32'h0000_0000);
        pulse0(1);
        rchk(PEND_OFS, 32'h0000_0000);
        pins(8'h01);
        rchk(PEND_OFS, 32'h0000_0001);
        pins(8'h00);
        wr32(FILT_OFS, 32'h0007_0001);
        wr32(FCLR_OFS, 32'h0000_0000);
        pulse0(1);
        rchk(PEND_OFS, 32'h0000_0001);
        for (int s = 0; s < 8; s++)
        begin
            wr32(FILT_OFS, {13'h0, s[2:0], 16'h0001});
            rchk(FILT_OFS, {13'h0, s[2:0], 16'h0001});
        end
        // slow tick source drops a pulse that the /2 source lets through
        wr32(FILT_OFS, 32'h0003_0001);
        wr32(FCLR_OFS, 32'h0000_0000);
        pulse0(4);
        rchk(PEND_OFS, 32'h0000_0000);
        wr32(FILT_OFS, 32'h0000_0001);
        pulse0(4);
        rchk(PEND_OFS, 32'h0000_0001);
        rd32(8'h44, d, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        chk(d, 32'h0000_0000);
        wr32(8'h44, 32'h0000_0001);
        chk({30'h0, wresp}, {30'h0, RESP_SLVERR});
    endtask : t_filter
    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial
    begin
        repeat (6) @(posedge i_clk);
        chk({24'h0, i_gpio_irq_filter_output_ctrl.pin_level_r}, {24'h0, PORT_A_LVL});
        chk({24'h0, opin}, {24'h0, OUT_LVL_RST});
        i_arst_n <= 1'b1;
        t_reset();
        t_out();
        t_irq();
        t_filter();
        end_sim();
    end
endmodule : tb_top
